/* rtl/jtp_pkg.sv */
// jtp_pkg: constants, states and state record of the test port
// assumes a 20 MHz system clock that oversamples the test clock pin

package jtp_pkg;

    // =====================================================================
    // widths and codes
    localparam int          IR_W          = 4;         // instruction length
    localparam int          DR_W          = 8;         // data word length
    localparam int          FIFO_DEPTH    = 8;         // words held for user
    localparam logic [3:0]  IR_CAPTURE    = 4'h1;      // fixed capture pattern
    localparam logic [3:0]  INS_BYPASS    = 4'hf;      // one-bit bypass path
    localparam logic [3:0]  INS_DATA      = 4'h1;      // word to fifo path
    localparam logic [2:0]  TLR_TMS_COUNT = 3'h5;      // tms-high edges to reset

    // =====================================================================
    // controller states
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } jtp_state_t;

    // =====================================================================
    // state of the port logic, except trst_sync, tms_hi_cnt and the fifo
    typedef struct packed {
        jtp_state_t        state;    // controller state
        logic [IR_W-1:0]   ir;       // active instruction
        logic [IR_W-1:0]   ir_sh;    // instruction shifter
        logic [DR_W-1:0]   dr_sh;    // data shifter
        logic              byp;      // bypass bit
        logic              tdo;      // serial output bit
        logic              tdo_oe;   // serial output enable
        logic              push;     // word push pulse
        logic              tck_m;    // test clock sync, first stage
        logic              tck_s;    // test clock sync, second stage
        logic              tck_d;    // test clock delayed for edges
        logic              tms_m;    // mode select sync, first stage
        logic              tms_s;    // mode select sync, second stage
        logic              tdi_m;    // data in sync, first stage
        logic              tdi_s;    // data in sync, second stage
    } jtp_tap_t;

    localparam jtp_tap_t TAP_RESET = '{
        state: TLR, ir: INS_BYPASS, ir_sh: 4'h0, dr_sh: 8'h00, byp: 1'b0,
        tdo: 1'b0, tdo_oe: 1'b0, push: 1'b0, tck_m: 1'b0, tck_s: 1'b0,
        tck_d: 1'b0, tms_m: 1'b1, tms_s: 1'b1, tdi_m: 1'b1, tdi_s: 1'b1
    };

endpackage : jtp_pkg

/* rtl/jtp_fifo.sv */
// jtp_fifo: word buffer with valid and ready on both sides
// assumes one clock; reset is asynchronous, active low
`timescale 1ns/1ps

module jtp_fifo #(
    parameter int W = 8,                       // word width
    parameter int D = 8                        // depth in words
) (
    input  wire logic         clk_i,           // clock
    input  wire logic         rstn_i,          // async reset, low
    input  wire logic         in_valid_i,      // word offered
    output logic              in_ready_o,      // room for a word
    input  wire logic [W-1:0] in_data_i,       // word in
    output logic              out_valid_o,     // word available
    input  wire logic         out_ready_i,     // drain accepts
    output logic [W-1:0]      out_data_o       // word out
);

    localparam int PW = $clog2(D);

    typedef struct packed {
        logic [PW:0] wr;                       // write pointer with wrap bit
        logic [PW:0] rd;                       // read pointer with wrap bit
    } jtp_fifo_t;

    jtp_fifo_t        s;
    jtp_fifo_t        next_s;
    logic [W-1:0]     mem [D];
    logic             do_wr;
    logic             do_rd;

    // =====================================================================
    // full and empty from pointers
    assign in_ready_o  = !((s.wr[PW] != s.rd[PW]) && (s.wr[PW-1:0] == s.rd[PW-1:0]));
    assign out_valid_o = (s.wr != s.rd);
    assign out_data_o  = mem[s.rd[PW-1:0]];
    assign do_wr       = in_valid_i && in_ready_o;
    assign do_rd       = out_valid_o && out_ready_i;

    // pointer advance
    always_comb begin
        next_s = s;
        if (do_wr) begin
            next_s.wr = s.wr + 1'b1;
        end
        if (do_rd) begin
            next_s.rd = s.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[s.wr[PW-1:0]] <= in_data_i;
        end
    end

endmodule : jtp_fifo

/* rtl/jtp_port.sv */
// jtp_port: boundary test port pins, controller, shifters, word fifo
// assumes the probe's test clock is far slower than sys_clk_i (8x or more)
`timescale 1ns/1ps

module jtp_port
    import jtp_pkg::*;
(
    input  wire logic            sys_clk_i,          // system clock, 20 MHz
    input  wire logic            rstn_i,             // chip reset, low
    input  wire logic            tck_i,              // test clock pin
    input  wire logic            tms_i,              // mode select pin
    input  wire logic            tdi_i,              // serial data in pin
    input  wire logic            trst_n_i,           // test reset pin, low
    input  wire logic            pad_pull_disable_i, // pull-disable bit
    output logic                 tdo_o,              // serial data out
    output logic                 tdo_oe_o,           // serial out enable
    output logic                 tck_pulldown_en_o,  // tck pull-down on
    output logic                 tms_pullup_en_o,    // tms pull-up on
    output logic                 tdi_pullup_en_o,    // tdi pull-up on
    output logic                 trst_pullup_en_o,   // trst pull-up on
    output logic [DR_W-1:0]      rx_data_o,          // received word
    output logic                 rx_valid_o,         // word available
    input  wire logic            rx_ready_i          // user takes word
);

    jtp_tap_t     s;
    jtp_tap_t     next_s;
    logic [1:0]   trst_sync;
    logic         test_rst_n;
    logic         rise;
    logic         fall;
    logic         fifo_in_ready;
    logic [2:0]   tms_hi_cnt;

    // =====================================================================
    // controller next state
    function automatic jtp_state_t jtp_next_state(input jtp_state_t st, input logic m);
        jtp_state_t n;
        n = st;
        case (st)
            TLR:     n = m ? TLR    : RTI;
            RTI:     n = m ? SEL_DR : RTI;
            SEL_DR:  n = m ? SEL_IR : CAP_DR;
            CAP_DR:  n = m ? EX1_DR : SH_DR;
            SH_DR:   n = m ? EX1_DR : SH_DR;
            EX1_DR:  n = m ? UPD_DR : PA_DR;
            PA_DR:   n = m ? EX2_DR : PA_DR;
            EX2_DR:  n = m ? UPD_DR : SH_DR;
            UPD_DR:  n = m ? SEL_DR : RTI;
            SEL_IR:  n = m ? TLR    : CAP_IR;
            CAP_IR:  n = m ? EX1_IR : SH_IR;
            SH_IR:   n = m ? EX1_IR : SH_IR;
            EX1_IR:  n = m ? UPD_IR : PA_IR;
            PA_IR:   n = m ? EX2_IR : PA_IR;
            EX2_IR:  n = m ? UPD_IR : SH_IR;
            UPD_IR:  n = m ? SEL_DR : RTI;
            default: n = TLR;
        endcase
        return n;
    endfunction : jtp_next_state

    // =====================================================================
    // test reset: async assert, release through two flops
    always_ff @(posedge sys_clk_i or negedge trst_n_i) begin
        if (!trst_n_i) begin
            trst_sync <= 2'h0;
        end else begin
            trst_sync <= {trst_sync[0], 1'b1};
        end
    end
    assign test_rst_n = trst_sync[1];

    // pad pull controls
    assign tck_pulldown_en_o = 1'b1;
    assign tms_pullup_en_o   = !pad_pull_disable_i;
    assign tdi_pullup_en_o   = !pad_pull_disable_i;
    assign trst_pullup_en_o  = !pad_pull_disable_i;

    // test clock edges from synchronised pin
    assign rise = s.tck_s && !s.tck_d;
    assign fall = !s.tck_s && s.tck_d;

    // =====================================================================
    // controller, shifters, serial output
    always_comb begin
        next_s       = s;
        next_s.push  = 1'b0;
        next_s.tck_m = tck_i;
        next_s.tck_s = s.tck_m;
        next_s.tck_d = s.tck_s;
        next_s.tms_m = tms_i;
        next_s.tms_s = s.tms_m;
        next_s.tdi_m = tdi_i;
        next_s.tdi_s = s.tdi_m;
        if (rise) begin
            next_s.state = jtp_next_state(s.state, s.tms_s);
            case (s.state)
                TLR: begin
                    next_s.ir = INS_BYPASS;
                end
                CAP_DR: begin
                    next_s.dr_sh = {{(DR_W-1){1'b0}}, fifo_in_ready};
                    next_s.byp   = 1'b0;
                end
                SH_DR: begin
                    next_s.dr_sh = {s.tdi_s, s.dr_sh[DR_W-1:1]};
                    next_s.byp   = s.tdi_s;
                end
                CAP_IR: begin
                    next_s.ir_sh = IR_CAPTURE;
                end
                SH_IR: begin
                    next_s.ir_sh = {s.tdi_s, s.ir_sh[IR_W-1:1]};
                end
                UPD_IR: begin
                    next_s.ir = s.ir_sh;
                end
                default: begin
                end
            endcase
            // word goes to fifo on entry to update
            if (next_s.state == UPD_DR && s.ir == INS_DATA) begin
                next_s.push = 1'b1;
            end
        end
        if (fall) begin
            next_s.tdo_oe = (s.state == SH_DR) || (s.state == SH_IR);
            if (s.state == SH_IR) begin
                next_s.tdo = s.ir_sh[0];
            end else if (s.state == SH_DR) begin
                next_s.tdo = (s.ir == INS_DATA) ? s.dr_sh[0] : s.byp;
            end
        end
    end

    // only the test reset clears this; chip reset does not
    always_ff @(posedge sys_clk_i or negedge test_rst_n) begin
        if (!test_rst_n) begin
            s <= TAP_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign tdo_o    = s.tdo;
    assign tdo_oe_o = s.tdo_oe;

    // =====================================================================
    // received words, drained by the user side
    jtp_fifo #(
        .W (DR_W),
        .D (FIFO_DEPTH)
    ) jtp_fifo_i (
        .clk_i       (sys_clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (s.push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (s.dr_sh),
        .out_valid_o (rx_valid_o),
        .out_ready_i (rx_ready_i),
        .out_data_o  (rx_data_o)
    );

    // =====================================================================
    // helper: consecutive tms-high rising edges, saturating
    always_ff @(posedge sys_clk_i or negedge test_rst_n) begin
        if (!test_rst_n) begin
            tms_hi_cnt <= 3'h0;
        end else if (rise) begin
            if (!s.tms_s) begin
                tms_hi_cnt <= 3'h0;
            end else if (tms_hi_cnt != TLR_TMS_COUNT) begin
                tms_hi_cnt <= tms_hi_cnt + 3'h1;
            end
        end
    end

    // assertions
    AST_TCK_PULL: assert property (@(posedge sys_clk_i) tck_pulldown_en_o == 1'b1)
        else $error("tck pull-down switched off");

    AST_PULL_DIS: assert property (@(posedge sys_clk_i)
        (tms_pullup_en_o == !pad_pull_disable_i) && (tdi_pullup_en_o == tms_pullup_en_o)
        && (trst_pullup_en_o == tms_pullup_en_o))
        else $error("pull enables disagree with pull-disable bit");

    AST_STATE_ON_RISE: assert property (@(posedge sys_clk_i) disable iff (!test_rst_n)
        (s.state != $past(s.state)) |-> $past(rise))
        else $error("controller moved without a rising test clock edge");

    AST_TDO_ON_FALL: assert property (@(posedge sys_clk_i) disable iff (!test_rst_n)
        (tdo_o != $past(tdo_o)) || (tdo_oe_o != $past(tdo_oe_o)) |-> $past(fall))
        else $error("serial output changed without a falling edge");

    AST_OE_SHIFT: assert property (@(posedge sys_clk_i) disable iff (!test_rst_n)
        $rose(tdo_oe_o) |-> $past(s.state == SH_DR || s.state == SH_IR))
        else $error("serial output enabled outside a shift state");

    AST_OE_RESET: assert property (@(posedge sys_clk_i)
        !test_rst_n |-> !tdo_oe_o && s.state == TLR)
        else $error("serial output driven or controller active in test reset");

    AST_TLR_FIVE: assert property (@(posedge sys_clk_i) disable iff (!test_rst_n)
        tms_hi_cnt == TLR_TMS_COUNT |-> s.state == TLR)
        else $error("five tms-high edges did not reach logic reset");

    AST_SHIFT_TDI: assert property (@(posedge sys_clk_i) disable iff (!test_rst_n)
        rise && s.state == SH_DR |=>
        s.dr_sh[DR_W-1] == $past(s.tdi_s) && s.byp == $past(s.tdi_s))
        else $error("data input not shifted on rising edge");

    AST_TMS_STEP: assert property (@(posedge sys_clk_i) disable iff (!test_rst_n)
        rise && s.state == RTI && s.tms_s |=> s.state == SEL_DR)
        else $error("mode select high in idle did not select data path");

    AST_CHIP_RST: assert property (@(posedge sys_clk_i) disable iff (!test_rst_n)
        !rstn_i && !rise |=> s.state == $past(s.state) && s.ir == $past(s.ir))
        else $error("chip reset disturbed test port state");

endmodule : jtp_port

/* test/jtp_probe.sv */
// jtp_probe: test probe model driving clock, mode, data and test reset
// assumes sys_clk_i from the bench; pins change at its falling edge
`timescale 1ns/1ps

module jtp_probe (
    input  wire logic sys_clk_i, // bench clock
    input  wire logic tdo_i,     // resolved serial out wire
    output logic      tck_o,     // test clock
    output logic      tms_o,     // mode select
    output logic      tdi_o,     // serial data in
    output logic      trst_n_o   // test reset, low
);
    // =====================================================================
    // idle levels; clock parked low between frames
    initial begin
        tck_o    = 1'b0;
        tms_o    = 1'b1;
        tdi_o    = 1'b1;
        trst_n_o = 1'b0;
    end

    // one 400 ns test clock period; tdo taken at the rising edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        repeat (4) @(negedge sys_clk_i);
        tck_o = 1'b1;
        tdo   = tdo_i;
        repeat (4) @(negedge sys_clk_i);
        tck_o = 1'b0;
    endtask : step

    // test reset level
    task automatic set_trst(input logic v);
        trst_n_o = v;
    endtask : set_trst
endmodule : jtp_probe

/* test/jtp_port_tb.sv */
// jtp_port_tb: self-checking bench of the test port with a probe model
// assumes design files compiled first; 20 MHz clock, 400 ns test clock
`timescale 1ns/1ps

module jtp_port_tb
    import jtp_pkg::*;
;
    logic            sys_clk = 1'b0;
    logic            rstn    = 1'b0;
    logic            pdd     = 1'b0;
    logic            rx_ready = 1'b0;
    logic            tck, tms, tdi, trst_n, tdo, tdo_oe, tck_pd;
    logic            tms_pu, tdi_pu, trst_pu, rx_valid;
    logic [DR_W-1:0] rx_data;
    wire             tdo_w = tdo_oe ? tdo : 1'bz;
    int              miscompares = 0;
    int              n_checks    = 0;

    // =====================================================================
    // clock and instances
    always #25 sys_clk = ~sys_clk;

    jtp_port jtp_port_i (
        .sys_clk_i(sys_clk), .rstn_i(rstn), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .trst_n_i(trst_n), .pad_pull_disable_i(pdd), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .tck_pulldown_en_o(tck_pd), .tms_pullup_en_o(tms_pu), .tdi_pullup_en_o(tdi_pu),
        .trst_pullup_en_o(trst_pu), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready)
    );

    jtp_probe jtp_probe_i (
        .sys_clk_i(sys_clk), .tdo_i(tdo_w), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .trst_n_o(trst_n)
    );

    // =====================================================================
    // compares, reporting and end of run
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t bit got %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t word got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // =====================================================================
    // helpers: full scan from idle back to idle, step runs, one pop
    task automatic scan(input logic ir, input int n, input logic [7:0] din,
                        output logic [7:0] cap);
        logic b;
        cap = 8'h00;
        jtp_probe_i.step(1'b1, 1'b1, b);
        if (ir) jtp_probe_i.step(1'b1, 1'b1, b);
        jtp_probe_i.step(1'b0, 1'b1, b);
        jtp_probe_i.step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            jtp_probe_i.step(i == n - 1, din[i], b);
            cap[i] = b;
        end
        jtp_probe_i.step(1'b1, 1'b1, b);
        jtp_probe_i.step(1'b0, 1'b1, b);
    endtask : scan

    task automatic steps(input logic [7:0] pat, input int n);
        logic b;
        for (int i = 0; i < n; i++) jtp_probe_i.step(pat[i], 1'b0, b);
    endtask : steps

    task automatic pop_chk(input logic [7:0] exp);
        chk_bit(rx_valid, 1'b1);
        chk_word(rx_data, exp);
        rx_ready = 1'b1;
        @(negedge sys_clk);
        rx_ready = 1'b0;
        @(negedge sys_clk);
    endtask : pop_chk

    // =====================================================================
    // scenarios
    task automatic t_pins();
        for (int p = 0; p < 2; p++) begin
            pdd = p[0];
            @(negedge sys_clk);
            chk_bit(tck_pd, 1'b1);
            chk_bit(tms_pu, ~p[0]);
            chk_bit(tdi_pu, ~p[0]);
            chk_bit(trst_pu, ~p[0]);
            chk_bit(tdo_oe, 1'b0);
        end
        $display("test pins done");
    endtask : t_pins

    task automatic t_data();
        logic [7:0] cap;
        scan(1'b1, IR_W, {4'h0, INS_DATA}, cap);
        chk_word(cap, {4'h0, IR_CAPTURE});
        chk_bit(tdo_oe, 1'b0);
        scan(1'b0, DR_W, 8'ha5, cap);
        chk_word(cap, 8'h01);
        pop_chk(8'ha5);
        $display("test data done");
    endtask : t_data

    task automatic t_chip_rst();
        logic [7:0] cap;
        scan(1'b0, DR_W, 8'h3c, cap);
        rstn = 1'b0;
        @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        chk_bit(rx_valid, 1'b0);
        scan(1'b0, DR_W, 8'h5a, cap);
        chk_word(cap, 8'h01);
        pop_chk(8'h5a);
        $display("test chip reset done");
    endtask : t_chip_rst

    task automatic t_full();
        logic [7:0] cap;
        for (int i = 0; i < 9; i++) begin
            scan(1'b0, DR_W, 8'h10 + i[7:0], cap);
            chk_word(cap, (i < FIFO_DEPTH) ? 8'h01 : 8'h00);
        end
        for (int i = 0; i < FIFO_DEPTH; i++) pop_chk(8'h10 + i[7:0]);
        chk_bit(rx_valid, 1'b0);
        $display("test full done");
    endtask : t_full

    task automatic t_tlr();
        logic [7:0] cap;
        steps(8'h01, 3);
        steps(8'h1f, 5);
        // the run passes update with one shifted zero, so a zero word lands
        pop_chk(8'h00);
        steps(8'h00, 1);
        scan(1'b0, DR_W, 8'h01, cap);
        chk_word(cap, 8'h02);
        chk_bit(rx_valid, 1'b0);
        $display("test logic reset done");
    endtask : t_tlr

    task automatic t_trst();
        logic [7:0] cap;
        scan(1'b1, IR_W, {4'h0, INS_DATA}, cap);
        steps(8'h01, 4);
        chk_bit(tdo_oe, 1'b1);
        jtp_probe_i.set_trst(1'b0);
        repeat (2) @(negedge sys_clk);
        chk_bit(tdo_oe, 1'b0);
        jtp_probe_i.set_trst(1'b1);
        repeat (3) @(negedge sys_clk);
        steps(8'h00, 1);
        scan(1'b0, DR_W, 8'h01, cap);
        chk_word(cap, 8'h02);
        $display("test test reset done");
    endtask : t_trst

    // =====================================================================
    // main sequence: both resets together, then the scenarios
    initial begin
        repeat (10) @(negedge sys_clk);
        rstn = 1'b1;
        jtp_probe_i.set_trst(1'b1);
        repeat (3) @(negedge sys_clk);
        t_pins();
        steps(8'h00, 1);
        t_data();
        t_chip_rst();
        t_full();
        t_tlr();
        t_trst();
        conclude();
    end

    // watchdog against a hang
    initial begin
        #(20000 * 50);
        miscompares++;
        conclude();
    end
endmodule : jtp_port_tb
